/* rtcsa_regs.vh */
// Register map, field positions, reset values and timing figures of the RTC status and interrupt block.
// Assumes a single 50 MHz clock; every time below except the trim interval, which stays a count of seconds, is converted to cycles inside the modules.
`ifndef RTCSA_REGS_VH
`define RTCSA_REGS_VH

`define RTCSA_ADDR_W 4
`define RTCSA_ADDR_TRIM 4'h7
`define RTCSA_ADDR_CTRL_ONE 4'he
`define RTCSA_ADDR_CTRL_TWO 4'hf

`define RTCSA_C1_WEEKLY_EN 7
`define RTCSA_C1_DAILY_EN 6
`define RTCSA_C1_HOUR_FMT 5
`define RTCSA_C1_USER3 4
`define RTCSA_C1_TEST 3
`define RTCSA_C1_PSEL_HI 2
`define RTCSA_C1_PSEL_LO 0

`define RTCSA_C2_LV_SEL 7
`define RTCSA_C2_LV_FLAG 6
`define RTCSA_C2_HALT_FLAG 5
`define RTCSA_C2_USER1 4
`define RTCSA_C2_USER2 3
`define RTCSA_C2_PER_FLAG 2
`define RTCSA_C2_WEEKLY_FLAG 1
`define RTCSA_C2_DAILY_FLAG 0

`define RTCSA_RST_CTRL_ONE 8'h00
`define RTCSA_RST_TRIM 7'h00

`define RTCSA_PSEL_OFF 3'h0
`define RTCSA_PSEL_LOW 3'h1
`define RTCSA_PSEL_2HZ 3'h2
`define RTCSA_PSEL_1HZ 3'h3
`define RTCSA_PSEL_SEC 3'h4
`define RTCSA_PSEL_MIN 3'h5
`define RTCSA_PSEL_HOUR 3'h6
`define RTCSA_PSEL_MONTH 3'h7

`define RTCSA_CLK_HZ 50000000
`define RTCSA_SECOND_MS 1000
`define RTCSA_SAMPLE_MS_X10 78
`define RTCSA_INC_DELAY_US 92
`define RTCSA_TRIM_STEP_NS 61035
`define RTCSA_TRIM_SECONDS 20

`endif

/* rtcsa_second_gen.v */
// Second divider with trim: marks the start of each second, its quarters and the delayed second increment.
// Assumes restart comes from logic on the same clock; the trim code is held stable by the register file.
module rtcsa_second_gen #(
  parameter SEC_CYCLES = 50000000,
  parameter INC_DELAY = 4600,
  parameter TRIM_STEP = 3051,
  parameter TRIM_SECONDS = 20
) (
  input wire clk,
  input wire rst_n,
  input wire restart,
  input wire [6:0] trimCode,
  output reg periodStart,
  output reg secondTick,
  output reg [1:0] quarter
);

  localparam [31:0] QTR = SEC_CYCLES / 4;

  // Positive result lengthens the adjusted second, negative shortens it; neutral codes give zero.
  function signed [31:0] trimAdjust;
    input [6:0] code;
    begin
      trimAdjust = 32'sd0;
      if (code >= 7'h02 && code <= 7'h3f) begin
        trimAdjust = $signed({25'd0, code - 7'h01}) * TRIM_STEP;
      end else if (code >= 7'h42) begin
        trimAdjust = -($signed({25'd0, 7'h00 - code}) * TRIM_STEP);
      end
    end
  endfunction

  reg [31:0] cnt_q;
  reg [4:0] secIdx_q;
  reg [31:0] delayCnt_q;
  reg delayRun_q;
  wire [31:0] periodLen;
  wire lastCycle;

  // Only one second in every trim interval is stretched or squeezed, which keeps the jitter bounded.
  assign periodLen = (secIdx_q == TRIM_SECONDS - 1) ? SEC_CYCLES + trimAdjust(trimCode) : SEC_CYCLES;
  assign lastCycle = (cnt_q >= periodLen - 1);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
      secIdx_q <= 5'h00;
      periodStart <= 1'b0;
      quarter <= 2'h0;
    end else if (restart) begin
      cnt_q <= 32'h0000_0000;
      periodStart <= 1'b0;
      quarter <= 2'h0;
    end else begin
      periodStart <= lastCycle;
      if (lastCycle) begin
        cnt_q <= 32'h0000_0000;
        quarter <= 2'h0;
        secIdx_q <= (secIdx_q == TRIM_SECONDS - 1) ? 5'h00 : secIdx_q + 5'h01;
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
        if (cnt_q + 32'h0000_0001 == QTR || cnt_q + 32'h0000_0001 == 2 * QTR || cnt_q + 32'h0000_0001 == 3 * QTR) begin
          quarter <= quarter + 2'h1;
        end
      end
    end
  end

  // The counters advance a fixed delay after the falling edge of the pulse output.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delayCnt_q <= 32'h0000_0000;
      delayRun_q <= 1'b0;
      secondTick <= 1'b0;
    end else if (restart) begin
      delayCnt_q <= 32'h0000_0000;
      delayRun_q <= 1'b0;
      secondTick <= 1'b0;
    end else begin
      secondTick <= 1'b0;
      if (periodStart) begin
        delayRun_q <= 1'b1;
        delayCnt_q <= 32'h0000_0001;
      end else if (delayRun_q) begin
        if (delayCnt_q >= INC_DELAY) begin
          delayRun_q <= 1'b0;
          secondTick <= 1'b1;
        end else begin
          delayCnt_q <= delayCnt_q + 32'h0000_0001;
        end
      end
    end
  end

endmodule // rtcsa_second_gen

/* rtcsa_status_irq.v */
// Status flags, control registers, alarm comparators and periodic interrupt of the real-time clock.
// Assumes the time counters run on clk and report minute, hour and month starts as one-cycle pulses.
`include "rtcsa_regs.vh"
module rtcsa_status_irq #(
  parameter SEC_CYCLES = `RTCSA_CLK_HZ / 1000 * `RTCSA_SECOND_MS,
  parameter SAMPLE_CYCLES = `RTCSA_CLK_HZ / 10000 * `RTCSA_SAMPLE_MS_X10,
  parameter INC_DELAY = `RTCSA_CLK_HZ / 1000000 * `RTCSA_INC_DELAY_US
) (
  input wire clk,
  input wire rst_n,
  input wire regWrite,
  input wire [`RTCSA_ADDR_W-1:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  input wire secondsWrite,
  input wire minuteStart,
  input wire hourStart,
  input wire monthStart,
  input wire [2:0] curWeekday,
  input wire [5:0] curHour,
  input wire [6:0] curMinute,
  input wire [6:0] weeklyAlarmDays,
  input wire [5:0] weeklyAlarmHour,
  input wire [6:0] weeklyAlarmMinute,
  input wire [5:0] dailyAlarmHour,
  input wire [6:0] dailyAlarmMinute,
  input wire oscStopped,
  input wire supplyBelowHigh,
  input wire supplyBelowLow,
  output wire secondTick,
  output reg monitorActive,
  output wire hourFormat,
  input wire irqPinAIn,
  output wire irqPinAOut,
  output reg irqPinAOe,
  input wire irqPinBIn,
  output wire irqPinBOut,
  output reg irqPinBOe
);

  localparam [63:0] TRIM_STEP_64 = 64'd`RTCSA_TRIM_STEP_NS * SEC_CYCLES / 64'd1000000000;
  localparam TRIM_STEP = (TRIM_STEP_64 < 64'd1) ? 1 : TRIM_STEP_64[31:0];

  // One-hot view of the periodic output mode.
  localparam [2:0] MODE_OFF = 3'b001;
  localparam [2:0] MODE_PULSE = 3'b010;
  localparam [2:0] MODE_LEVEL = 3'b100;

  function hitAddr;
    input [`RTCSA_ADDR_W-1:0] addr;
    input [`RTCSA_ADDR_W-1:0] target;
    begin
      hitAddr = (addr == target);
    end
  endfunction

  // Two-flop synchronisers for the analog detector levels.
  wire [2:0] rawIn;
  wire [2:0] syncIn;
  assign rawIn = {oscStopped, supplyBelowHigh, supplyBelowLow};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gSync
      reg meta_q;
      reg sync_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= rawIn[g];
          sync_q <= meta_q;
        end
      end
      assign syncIn[g] = sync_q;
    end
  endgenerate
  wire haltEvent;
  wire belowHigh;
  wire belowLow;
  assign haltEvent = syncIn[2];
  assign belowHigh = syncIn[1];
  assign belowLow = syncIn[0];

  reg [7:0] ctrlOne_q;
  reg [6:0] trim_q;
  reg lvSel_q;
  reg lvFlag_q;
  reg haltFlag_q;
  reg user1_q;
  reg user2_q;
  reg perFlag_q;
  reg weeklyFlag_q;
  reg dailyFlag_q;
  reg [31:0] winCnt_q;
  reg winActive_q;

  wire periodStart;
  wire [1:0] quarter;
  wire [2:0] perSel;
  wire wrOne;
  wire wrTwo;
  wire wrTrim;
  assign perSel = ctrlOne_q[`RTCSA_C1_PSEL_HI:`RTCSA_C1_PSEL_LO];
  assign wrOne = regWrite && hitAddr(regAddr, `RTCSA_ADDR_CTRL_ONE);
  assign wrTwo = regWrite && hitAddr(regAddr, `RTCSA_ADDR_CTRL_TWO);
  assign wrTrim = regWrite && hitAddr(regAddr, `RTCSA_ADDR_TRIM);
  assign hourFormat = ctrlOne_q[`RTCSA_C1_HOUR_FMT];

  rtcsa_second_gen #(
    .SEC_CYCLES(SEC_CYCLES),
    .INC_DELAY(INC_DELAY),
    .TRIM_STEP(TRIM_STEP),
    .TRIM_SECONDS(`RTCSA_TRIM_SECONDS)
  ) uSecond (
    .clk(clk),
    .rst_n(rst_n),
    .restart(secondsWrite),
    .trimCode(trim_q),
    .periodStart(periodStart),
    .secondTick(secondTick),
    .quarter(quarter)
  );

  reg [2:0] mode;
  always @* begin
    case (perSel)
      `RTCSA_PSEL_OFF, `RTCSA_PSEL_LOW: mode = MODE_OFF;
      `RTCSA_PSEL_2HZ, `RTCSA_PSEL_1HZ: mode = MODE_PULSE;
      default: mode = MODE_LEVEL;
    endcase
  end

  // Level-mode boundary events; the boundary pulses arrive with the counters already at 00 seconds.
  reg levelEvent;
  always @* begin
    case (perSel)
      `RTCSA_PSEL_SEC: levelEvent = secondTick;
      `RTCSA_PSEL_MIN: levelEvent = minuteStart;
      `RTCSA_PSEL_HOUR: levelEvent = hourStart;
      `RTCSA_PSEL_MONTH: levelEvent = monthStart;
      default: levelEvent = 1'b0;
    endcase
  end

  // Pulse output is low in the first half of each second (1 Hz) or each half second (2 Hz).
  reg pulseLow;
  always @* begin
    case (perSel)
      `RTCSA_PSEL_2HZ: pulseLow = ~quarter[0];
      `RTCSA_PSEL_1HZ: pulseLow = ~quarter[1];
      default: pulseLow = 1'b0;
    endcase
  end

  wire perSet;
  assign perSet = (mode == MODE_LEVEL) ? levelEvent : ((mode == MODE_PULSE) && periodStart);

  // Alarms are compared only on a minute change, so a whole matching minute sets a flag once.
  wire weeklyMatch;
  wire dailyMatch;
  wire weeklySet;
  wire dailySet;
  assign weeklyMatch = weeklyAlarmDays[curWeekday] && curHour == weeklyAlarmHour && curMinute == weeklyAlarmMinute;
  assign dailyMatch = curHour == dailyAlarmHour && curMinute == dailyAlarmMinute;
  assign weeklySet = minuteStart && weeklyMatch && ctrlOne_q[`RTCSA_C1_WEEKLY_EN];
  assign dailySet = minuteStart && dailyMatch && ctrlOne_q[`RTCSA_C1_DAILY_EN];

  // The detector is only trusted while the crystal runs, and the chosen threshold decides the trip.
  wire lvSet;
  assign lvSet = winActive_q && !haltFlag_q && (lvSel_q ? belowLow : belowHigh);

  // Write-zero clears; a hardware set in the same cycle wins over the clear.
  function clearKeep;
    input flag;
    input setIt;
    input wr;
    input bitVal;
    begin
      clearKeep = setIt | (flag & ~(wr & ~bitVal));
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlOne_q <= `RTCSA_RST_CTRL_ONE;
      trim_q <= `RTCSA_RST_TRIM;
      haltFlag_q <= 1'b1;
      lvSel_q <= 1'b0;
      lvFlag_q <= 1'b0;
      user1_q <= 1'b0;
      user2_q <= 1'b0;
      perFlag_q <= 1'b0;
      weeklyFlag_q <= 1'b0;
      dailyFlag_q <= 1'b0;
    end else if (haltEvent) begin
      // A stopped crystal means the stored settings are unreliable, so they are forced back to defaults.
      haltFlag_q <= 1'b1;
      ctrlOne_q <= `RTCSA_RST_CTRL_ONE;
      trim_q <= `RTCSA_RST_TRIM;
      lvSel_q <= 1'b0;
      lvFlag_q <= 1'b0;
      user1_q <= 1'b0;
      user2_q <= 1'b0;
      perFlag_q <= 1'b0;
      weeklyFlag_q <= 1'b0;
      dailyFlag_q <= 1'b0;
    end else begin
      if (wrOne) begin
        ctrlOne_q <= regWdata;
      end
      if (wrTrim) begin
        trim_q <= regWdata[6:0];
      end
      if (wrTwo) begin
        lvSel_q <= regWdata[`RTCSA_C2_LV_SEL];
        user1_q <= regWdata[`RTCSA_C2_USER1];
        user2_q <= regWdata[`RTCSA_C2_USER2];
      end
      haltFlag_q <= clearKeep(haltFlag_q, 1'b0, wrTwo, regWdata[`RTCSA_C2_HALT_FLAG]);
      lvFlag_q <= haltFlag_q ? 1'b0 : clearKeep(lvFlag_q, lvSet, wrTwo, regWdata[`RTCSA_C2_LV_FLAG]);
      perFlag_q <= clearKeep(perFlag_q, perSet, wrTwo, regWdata[`RTCSA_C2_PER_FLAG]);
      weeklyFlag_q <= clearKeep(weeklyFlag_q, weeklySet, wrTwo, regWdata[`RTCSA_C2_WEEKLY_FLAG]);
      dailyFlag_q <= clearKeep(dailyFlag_q, dailySet, wrTwo, regWdata[`RTCSA_C2_DAILY_FLAG]);
    end
  end

  // Sampling window opens at each second start and is skipped entirely while a drop is recorded.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      winCnt_q <= 32'h0000_0000;
      winActive_q <= 1'b0;
      monitorActive <= 1'b0;
    end else begin
      if (lvFlag_q || lvSet) begin
        winActive_q <= 1'b0;
        winCnt_q <= 32'h0000_0000;
      end else if (periodStart) begin
        winActive_q <= 1'b1;
        winCnt_q <= 32'h0000_0001;
      end else if (winActive_q) begin
        if (winCnt_q >= SAMPLE_CYCLES) begin
          winActive_q <= 1'b0;
        end else begin
          winCnt_q <= winCnt_q + 32'h0000_0001;
        end
      end
      monitorActive <= winActive_q;
    end
  end

  // Pin drivers; registered so each pin changes cleanly one cycle after its cause.
  wire perLow;
  assign perLow = (perSel == `RTCSA_PSEL_LOW) || ((mode == MODE_PULSE) && pulseLow) ||
                  ((mode == MODE_LEVEL) && perFlag_q);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPinAOe <= 1'b0;
      irqPinBOe <= 1'b0;
    end else begin
      irqPinAOe <= (dailyFlag_q && ctrlOne_q[`RTCSA_C1_DAILY_EN]) || perLow;
      irqPinBOe <= weeklyFlag_q && ctrlOne_q[`RTCSA_C1_WEEKLY_EN];
    end
  end
  // The drivers never source current; the pull-up returns the line high.
  assign irqPinAOut = 1'b0;
  assign irqPinBOut = 1'b0;

  // Read path; unmapped addresses read zero and reads have no side effects.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (hitAddr(regAddr, `RTCSA_ADDR_CTRL_ONE)) begin
      regRdata <= ctrlOne_q;
    end else if (hitAddr(regAddr, `RTCSA_ADDR_CTRL_TWO)) begin
      regRdata <= {lvSel_q, lvFlag_q, haltFlag_q, user1_q, user2_q, perFlag_q, weeklyFlag_q, dailyFlag_q};
    end else if (hitAddr(regAddr, `RTCSA_ADDR_TRIM)) begin
      regRdata <= {1'b0, trim_q};
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule // rtcsa_status_irq

/* rtcsa_status_irq_asserts.sv */
// Concurrent checks on the ports of the RTC status and interrupt block.
// Assumes one clock domain and an asynchronous active-low reset.
module rtcsa_status_irq_asserts #(
  parameter SAMPLE_CYCLES = 390000
) (
  input logic clk,
  input logic rst_n,
  input logic regWrite,
  input logic [3:0] regAddr,
  input logic [7:0] regRdata,
  input logic minuteStart,
  input logic oscStopped,
  input logic secondTick,
  input logic monitorActive,
  input logic irqPinAOut,
  input logic irqPinAOe,
  input logic irqPinBOut,
  input logic irqPinBOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Halt passes two sync stages, a flag stage and the pin register, so recent history must be quiet.
  logic [3:0] oscHist_q;
  int monRun_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscHist_q <= 4'h0;
      monRun_q <= 0;
    end else begin
      oscHist_q <= {oscHist_q[2:0], oscStopped};
      monRun_q <= monitorActive ? monRun_q + 1 : 0;
    end
  end
  AST_PINS_ONLY_PULL_LOW: assert property (irqPinAOut == 1'b0 && irqPinBOut == 1'b0)
    else $error("interrupt pin drives high");
  AST_PINS_RELEASED_AT_START: assert property ($rose(rst_n) |-> !irqPinAOe && !irqPinBOe)
    else $error("pin active right after reset");
  AST_HALT_RELEASES_PINS: assert property (oscStopped [*5] |=> !irqPinAOe && !irqPinBOe)
    else $error("pin still active while halted");
  AST_WINDOW_LENGTH: assert property (monRun_q <= SAMPLE_CYCLES)
    else $error("sampling window too long");
  AST_TICK_ONE_CYCLE: assert property (secondTick |=> !secondTick)
    else $error("second tick longer than one cycle");
  AST_UNMAPPED_READ_ZERO: assert property (!(regAddr inside {4'h7, 4'he, 4'hf}) |=> regRdata == 8'h00)
    else $error("unmapped address reads nonzero");
  AST_TRIM_TOP_BIT_ZERO: assert property (regAddr == 4'h7 |=> !regRdata[7])
    else $error("trim top bit reads one");
  AST_PINB_NEEDS_CAUSE: assert property ($rose(irqPinBOe) |-> $past(minuteStart, 2) || $past(regWrite) || $past(regWrite, 2))
    else $error("pin B active without a minute match");
  AST_PINB_HOLDS: assert property (irqPinBOe && !regWrite && !$past(regWrite) && oscHist_q == 4'h0 && !oscStopped |=> irqPinBOe)
    else $error("pin B released without a write");
  cover property ($rose(irqPinAOe));
  cover property ($rose(irqPinBOe));
  cover property ($rose(monitorActive));
endmodule // rtcsa_status_irq_asserts
bind rtcsa_status_irq rtcsa_status_irq_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_u (.clk, .rst_n, .regWrite,
  .regAddr, .regRdata, .minuteStart, .oscStopped, .secondTick, .monitorActive, .irqPinAOut, .irqPinAOe,
  .irqPinBOut, .irqPinBOe);

/* rtcsa_host_model.sv */
// Host side of the interrupt lines: pull-up resistors on both open-drain pins.
// Assumes the block's enables are high only while it pulls a pin low.
module rtcsa_host_model (
  input logic aOe,
  input logic bOe,
  output logic pinA,
  output logic pinB
);
  // A released line never floats, so the host always reads the pull-up level.
  assign pinA = aOe ? 1'b0 : 1'b1;
  assign pinB = bOe ? 1'b0 : 1'b1;
endmodule // rtcsa_host_model

/* tb_rtcsa_status_irq.sv */
// Bench for the RTC status and interrupt block: a table of register cases, then hand-written cases.
// Assumes shortened second and window counts and a host model that pulls the pins up.
module tb_rtcsa_status_irq;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEC = 400;
  // One trim step in cycles: twenty shortened seconds times 3.05 ppm rounds below one, so the floor of one applies.
  localparam int TSTEP = 1;
  logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0;
  logic oscStopped = 1'b0, supplyBelowHigh = 1'b0, supplyBelowLow = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic [2:0] curWeekday = 3'h2;
  logic [5:0] curHour = 6'h09;
  logic [6:0] curMinute = 7'h30;
  logic [6:0] wDays = 7'h04, aMin = 7'h30;
  logic [5:0] aHour = 6'h09;
  logic aOut, bOut;
  logic [7:0] regRdata;
  logic secondTick, monitorActive, hourFormat, pinA, pinB, aOe, bOe, seen;
  int n_fail = 0, check_count = 0, toTick, lowLen;
  // Address, write data, expected read-back.
  logic [19:0] rows [9] = '{20'hF_0000, 20'hF_FF98, 20'hF_0000, 20'hE_3838, 20'hE_0000,
    20'h7_C242, 20'h7_3F3F, 20'h7_0000, 20'h3_FF00};
  always #10 clk = ~clk;
  rtcsa_status_irq #(.SEC_CYCLES(SEC), .SAMPLE_CYCLES(20), .INC_DELAY(10)) dut_u (.clk, .rst_n, .regWrite,
    .regAddr, .regWdata, .regRdata, .secondsWrite(ev[3]), .minuteStart(ev[0]), .hourStart(ev[1]),
    .monthStart(ev[2]), .curWeekday, .curHour, .curMinute, .weeklyAlarmDays(wDays), .weeklyAlarmHour(aHour),
    .weeklyAlarmMinute(aMin), .dailyAlarmHour(aHour), .dailyAlarmMinute(aMin), .oscStopped,
    .supplyBelowHigh, .supplyBelowLow, .secondTick, .monitorActive, .hourFormat, .irqPinAIn(pinA),
    .irqPinAOut(aOut), .irqPinAOe(aOe), .irqPinBIn(pinB), .irqPinBOut(bOut), .irqPinBOe(bOe));
  rtcsa_host_model host_u (.aOe, .bOe, .pinA, .pinB);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    tick(2);
    chk8(regRdata, e);
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask
  task automatic waitv(ref logic s, input logic v);
    for (int k = 0; s !== v; k++) begin
      if (k > 2 * SEC) begin
        chk1(s, v);
        complete_run();
      end
      tick(1);
    end
  endtask
  task automatic window();
    waitv(monitorActive, 1'b0);
    waitv(monitorActive, 1'b1);
    tick(30);
  endtask
  // Any twenty consecutive seconds hold exactly one trimmed second, so the span does not depend on phase.
  task automatic trim_span(input logic [7:0] code, input int exp);
    int n;
    int len;
    wr(4'h7, code);
    tick(1);
    waitv(secondTick, 1'b1);
    n = 0;
    len = 0;
    while (n < 20 && len < 25 * SEC) begin
      tick(1);
      len++;
      if (secondTick === 1'b1) n++;
    end
    chk1(len == exp, 1'b1);
  endtask
  // Counts how long pin A stays low and where the second increment lands in it.
  task automatic measure();
    waitv(aOe, 1'b0);
    waitv(aOe, 1'b1);
    toTick = -1;
    for (lowLen = 0; aOe === 1'b1 && lowLen < SEC; lowLen++) begin
      if (secondTick === 1'b1 && toTick < 0) toTick = lowLen;
      tick(1);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    rd(4'hf, 8'h20);
    chk1(pinA & pinB, 1'b1);
    chk1(aOut | bOut, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], rows[i][7:0]);
    end
    wr(4'h7, 8'h10);
    wr(4'he, 8'hf9);
    tick(2);
    chk1(pinA, 1'b0);
    chk1(hourFormat, 1'b1);
    @(posedge clk);
    supplyBelowHigh <= 1'b1;
    window();
    rd(4'hf, 8'h40);
    seen = 1'b0;
    repeat (SEC + 40) begin
      tick(1);
      seen = seen | monitorActive;
    end
    chk1(seen, 1'b0);
    @(posedge clk);
    oscStopped <= 1'b1;
    tick(6);
    wr(4'he, 8'hff);
    rd(4'hf, 8'h20);
    rd(4'he, 8'h00);
    rd(4'h7, 8'h00);
    chk1(pinA, 1'b1);
    @(posedge clk);
    oscStopped <= 1'b0;
    supplyBelowHigh <= 1'b0;
    tick(4);
    // Select the low threshold: only the deeper drop may set the flag.
    wr(4'hf, 8'h80);
    @(posedge clk);
    supplyBelowHigh <= 1'b1;
    window();
    rd(4'hf, 8'h80);
    @(posedge clk);
    supplyBelowLow <= 1'b1;
    window();
    rd(4'hf, 8'hc0);
    @(posedge clk);
    supplyBelowHigh <= 1'b0;
    supplyBelowLow <= 1'b0;
    wr(4'hf, 8'h00);
    wr(4'he, 8'h04);
    waitv(secondTick, 1'b1);
    tick(3);
    rd(4'hf, 8'h04);
    tick(50);
    chk1(pinA, 1'b0);
    for (int m = 5; m <= 8; m++) begin
      wr(4'hf, 8'h00);
      tick(3);
      chk1(pinA, 1'b1);
      if (m == 8) break;
      wr(4'he, 8'(m));
      pulse(m - 5);
      tick(3);
      chk1(pinA, 1'b0);
    end
    for (int m = 2; m <= 3; m++) begin
      wr(4'he, 8'(m));
      measure();
      measure();
      chk1(lowLen >= SEC / 4 * (m - 1) - 2 && lowLen <= SEC / 4 * (m - 1) + 2, 1'b1);
    end
    chk1(toTick >= 8 && toTick <= 12, 1'b1);
    waitv(aOe, 1'b0);
    pulse(3);
    tick(3);
    chk1(pinA, 1'b0);
    trim_span(8'h05, 20 * SEC + 4 * TSTEP);
    trim_span(8'h7c, 20 * SEC - 4 * TSTEP);
    trim_span(8'h01, 20 * SEC);
    wr(4'he, 8'h00);
    wr(4'hf, 8'h00);
    wr(4'he, 8'h80);
    @(posedge clk);
    wDays <= 7'h01;
    pulse(0);
    tick(3);
    chk1(pinB, 1'b1);
    @(posedge clk);
    wDays <= 7'h04;
    for (int n = 0; n < 2; n++) begin
      pulse(0);
      tick(3);
      chk1(pinB, 1'b0);
      chk1(pinA, 1'b1);
      rd(4'hf, 8'h02);
      wr(4'hf, 8'h00);
      tick(20);
      chk1(pinB, 1'b1);
      rd(4'he, 8'h80);
    end
    pulse(0);
    wr(4'he, 8'h00);
    tick(3);
    chk1(pinB, 1'b1);
    @(posedge clk);
    curHour <= 6'h08;
    wr(4'he, 8'h40);
    pulse(0);
    tick(3);
    chk1(pinA, 1'b1);
    @(posedge clk);
    curHour <= 6'h09;
    pulse(0);
    tick(3);
    chk1(pinA, 1'b0);
    wr(4'he, 8'h41);
    wr(4'hf, 8'h00);
    tick(3);
    chk1(pinA, 1'b0);
    wr(4'he, 8'h40);
    tick(3);
    chk1(pinA, 1'b1);
    complete_run();
  end
endmodule // tb_rtcsa_status_irq
